// [verilog/cpu_exec_defines.svh]
// Register offsets, field positions, reset values and cycle counts of the execution unit
`ifndef CPU_EXEC_DEFINES_SVH
`define CPU_EXEC_DEFINES_SVH
`define ADR_CTRL       6'h00
`define ADR_OPA        6'h01
`define ADR_OPB        6'h02
`define ADR_IMM        6'h03
`define ADR_PTR        6'h04
`define ADR_PC         6'h05
`define ADR_FLAGS      6'h06
`define ADR_RESULT     6'h07
`define ADR_STATUS     6'h08
`define CTRL_GO_BIT    8
`define CTRL_LONG_BIT  9
`define STAT_BUSY_BIT  0
`define STAT_BAD_BIT   1
`define STAT_JUMP_BIT  2
`define STAT_CYC_LSB   4
`define FLAG_C         0
`define FLAG_Z         1
`define FLAG_N         2
`define FLAG_V         3
`define FLAG_S         4
`define FLAG_H         5
`define FLAGS_RESET    8'h00
`define CYC_ONE        2'h1
`define CYC_TWO        2'h2
`define CYC_THREE      2'h3
`define WIDE_PC_LIMIT  16
`endif

// [verilog/cpu_exec_pkg.sv]
// Types shared by the execution unit and its two datapath modules
package cpu_exec_pkg;
  typedef enum logic [4:0] {
    word_add_immediate, word_sub_immediate, sub_imm_with_borrow,
    and_immediate, or_immediate,
    unsigned_multiply, signed_multiply, mixed_sign_multiply,
    frac_unsigned_multiply, frac_signed_multiply, frac_mixed_multiply,
    pointer_jump, pointer_call, compare_skip_equal,
    io_bit_clear_skip, io_bit_set_skip,
    branch_signed_ge, branch_signed_lt, branch_half_carry_set,
    opLimit
  } op_e;
  typedef enum logic {idle, running} seq_e;
  typedef struct packed {
    logic [15:0] value;
    logic [7:0]  flags;
    logic        writeBack;
  } exec_s;
endpackage

// [verilog/alu_unit.sv]
// Word add/subtract, byte subtract with borrow and logic with immediate
`timescale 1ns/100ps
`include "cpu_exec_defines.svh"
module alu_unit
  import cpu_exec_pkg::*;
(
  input  wire op_e         op,
  input  wire logic [15:0] pair,
  input  wire logic [7:0]  imm,
  input  wire logic [7:0]  flagsIn,
  output exec_s            out
);
  wire logic [15:0] wordK    = {10'h000, imm[5:0]};
  wire logic [15:0] wordSum  = pair + wordK;
  wire logic [15:0] wordDiff = pair - wordK;
  wire logic [7:0]  rd       = pair[7:0];
  wire logic [7:0]  bDiff    = rd - imm - {7'h00, flagsIn[`FLAG_C]};
  wire logic [7:0]  andRes   = rd & imm;
  wire logic [7:0]  orRes    = rd | imm;
  logic [7:0] f;
  always_comb begin
    f = flagsIn;
    out = '{value: pair, flags: flagsIn, writeBack: 1'b0};
    unique case (op)
      word_add_immediate: begin
        f[`FLAG_C] = ~wordSum[15] & pair[15];
        f[`FLAG_V] = ~pair[15] & wordSum[15];
        f[`FLAG_N] = wordSum[15];
        f[`FLAG_Z] = wordSum == 16'h0000;
        out.value = wordSum;
      end
      word_sub_immediate: begin
        f[`FLAG_C] = wordDiff[15] & ~pair[15];
        f[`FLAG_V] = pair[15] & ~wordDiff[15];
        f[`FLAG_N] = wordDiff[15];
        f[`FLAG_Z] = wordDiff == 16'h0000;
        out.value = wordDiff;
      end
      sub_imm_with_borrow: begin
        f[`FLAG_H] = (~rd[3] & imm[3]) | (imm[3] & bDiff[3]) | (bDiff[3] & ~rd[3]);
        f[`FLAG_C] = (~rd[7] & imm[7]) | (imm[7] & bDiff[7]) | (bDiff[7] & ~rd[7]);
        f[`FLAG_V] = (rd[7] & ~imm[7] & ~bDiff[7]) | (~rd[7] & imm[7] & bDiff[7]);
        f[`FLAG_N] = bDiff[7];
        // Zero only survives a chain of subtractions if every byte was zero
        f[`FLAG_Z] = (bDiff == 8'h00) & flagsIn[`FLAG_Z];
        out.value = {pair[15:8], bDiff};
      end
      and_immediate, or_immediate: begin
        out.value[7:0] = (op == and_immediate) ? andRes : orRes;
        f[`FLAG_V] = 1'b0;
        f[`FLAG_N] = out.value[7];
        f[`FLAG_Z] = out.value[7:0] == 8'h00;
      end
      default: f = flagsIn;
    endcase
    f[`FLAG_S] = (op <= or_immediate) ? (f[`FLAG_N] ^ f[`FLAG_V]) : flagsIn[`FLAG_S];
    out.flags = f;
    out.writeBack = op <= or_immediate;
  end
endmodule

// [verilog/mul_unit.sv]
// Byte multiplier: unsigned, signed and mixed, plain and fractional
`timescale 1ns/100ps
`include "cpu_exec_defines.svh"
module mul_unit
  import cpu_exec_pkg::*;
(
  input  wire op_e        op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic [7:0] flagsIn,
  output exec_s           out
);
  wire logic        aSigned = op inside {signed_multiply, mixed_sign_multiply,
                                         frac_signed_multiply, frac_mixed_multiply};
  wire logic        bSigned = op inside {signed_multiply, frac_signed_multiply};
  wire logic        isFrac  = op inside {frac_unsigned_multiply, frac_signed_multiply,
                                         frac_mixed_multiply};
  wire logic        isMul   = (op >= unsigned_multiply) && (op <= frac_mixed_multiply);
  wire logic [17:0] full    = 18'($signed({aSigned & a[7], a}) * $signed({bSigned & b[7], b}));
  wire logic [15:0] prod    = full[15:0];
  wire logic [15:0] shifted = isFrac ? {prod[14:0], 1'b0} : prod;
  always_comb begin
    out.value = shifted;
    out.flags = flagsIn;
    out.writeBack = isMul;
    if (isMul) begin
      // Carry reports the product's top bit before the fractional shift
      out.flags[`FLAG_C] = prod[15];
      out.flags[`FLAG_Z] = shifted == 16'h0000;
    end
  end
endmodule

// [verilog/cpu_exec_unit.sv]
// Execution unit: Wishbone registers, cycle sequencer, flow control and flags
// Overview of operation
// - Word add of 6-bit constant to pair; flags Z,C,N,V,S; two cycles.
// - Word subtract of 6-bit constant from pair; flags Z,C,N,V,S; two cycles.
// - Byte minus constant minus carry; all six arithmetic flags; one cycle.
// - AND with constant; Z,N,V,S only, carry and half carry kept; one cycle.
// - OR with constant; Z,N,V,S only; one cycle.
// - Six multiply forms into result pair; fractional shifts left; Z,C; two cycles.
// - Pointer jump loads pointer into PC, upper bits zero; no flags; two cycles.
// - Pointer call likewise; two cycles for 16-bit PC, three for wider.
// - Compare-skip jumps over next instruction when equal; no flags; 1/2/3 cycles.
// - I/O bit skip on clear, or on set for the set variant; no flags.
// - Signed greater-or-equal branch when N xor V is zero; 1 or 2 cycles.
// - Signed less-than branch when N xor V is one; flags untouched.
// - Half-carry branch when H set; 1 cycle not taken, 2 taken.
`timescale 1ns/100ps
`include "cpu_exec_defines.svh"
module cpu_exec_unit
  import cpu_exec_pkg::*;
#(
  parameter int PC_BITS = 22
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  output logic             busy
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return r;
  endfunction

  op_e                opCode;
  logic               longNext;
  logic [15:0]        opA;
  logic [7:0]         opB;
  logic [7:0]         imm;
  logic [15:0]        ptr;
  logic [PC_BITS-1:0] pc;
  logic [7:0]         flags;
  logic [15:0]        result;
  logic               badOp;
  logic               jumped;
  logic [1:0]         lastCycles;
  seq_e               state;
  logic [1:0]         count;

  exec_s              aluOut;
  exec_s              mulOut;
  logic [PC_BITS-1:0] next_pc;
  logic [1:0]         cycles;
  logic               jump;

  // Bus decode; a write lands at the edge where ack is seen high
  wire logic        access   = cyc_i & stb_i;
  wire logic        wrStrobe = access & we_i & ack_o;
  wire logic [5:0]  word     = adr_i[7:2];
  // Operands are frozen while an operation runs, so writes then are dropped
  wire logic        wrOk     = wrStrobe & (state == idle);
  wire logic [31:0] ctrlWord = {22'h000000, longNext, 4'h0, opCode};
  wire logic [31:0] ctrlNew  = merge(ctrlWord, dat_i, sel_i);
  wire logic        goReq    = wrOk & (word == `ADR_CTRL) & ctrlNew[`CTRL_GO_BIT];
  wire logic        opLegal  = ctrlNew[4:0] < 5'(opLimit);
  wire logic        start    = goReq & opLegal;
  wire logic        isAlu    = opCode <= or_immediate;
  wire logic        isMul    = (opCode >= unsigned_multiply) &&
                               (opCode <= frac_mixed_multiply);
  wire exec_s       dataOut  = isMul ? mulOut : aluOut;

  alu_unit aluUnit (
    .op      (opCode),
    .pair    (opA),
    .imm     (imm),
    .flagsIn (flags),
    .out     (aluOut)
  );

  mul_unit mulUnit (
    .op      (opCode),
    .a       (opA[7:0]),
    .b       (opB),
    .flagsIn (flags),
    .out     (mulOut)
  );

  // Flow targets; PC wraps at its own width
  wire logic [PC_BITS-1:0] seqPc    = pc + PC_BITS'(1);
  wire logic [PC_BITS-1:0] skipPc   = pc + (longNext ? PC_BITS'(3) : PC_BITS'(2));
  wire logic [PC_BITS-1:0] relK     = PC_BITS'($signed(imm[6:0]));
  wire logic [PC_BITS-1:0] branchPc = pc + relK + PC_BITS'(1);
  wire logic [PC_BITS-1:0] ptrPc    = PC_BITS'(ptr);
  wire logic [1:0]         skipCyc  = longNext ? `CYC_THREE : `CYC_TWO;
  wire logic [1:0]         callCyc  = (PC_BITS > `WIDE_PC_LIMIT) ? `CYC_THREE : `CYC_TWO;
  wire logic               signedLt = flags[`FLAG_N] ^ flags[`FLAG_V];
  wire logic               ioBit    = opA[imm[2:0]];

  always_comb begin
    jump = 1'b0;
    next_pc = seqPc;
    cycles = `CYC_ONE;
    unique case (opCode)
      word_add_immediate, word_sub_immediate: cycles = `CYC_TWO;
      sub_imm_with_borrow, and_immediate, or_immediate: cycles = `CYC_ONE;
      unsigned_multiply, signed_multiply, mixed_sign_multiply,
      frac_unsigned_multiply, frac_signed_multiply, frac_mixed_multiply:
        cycles = `CYC_TWO;
      pointer_jump: begin
        jump = 1'b1;
        cycles = `CYC_TWO;
      end
      pointer_call: begin
        jump = 1'b1;
        cycles = callCyc;
      end
      compare_skip_equal: jump = opA[7:0] == opB;
      io_bit_clear_skip: jump = ~ioBit;
      io_bit_set_skip: jump = ioBit;
      branch_signed_ge: jump = ~signedLt;
      branch_signed_lt: jump = signedLt;
      branch_half_carry_set: jump = flags[`FLAG_H];
      default: jump = 1'b0;
    endcase
    if (opCode inside {pointer_jump, pointer_call}) begin
      next_pc = ptrPc;
    end else if (opCode inside {compare_skip_equal, io_bit_clear_skip, io_bit_set_skip}) begin
      next_pc = jump ? skipPc : seqPc;
      cycles = jump ? skipCyc : `CYC_ONE;
    end else if (opCode >= branch_signed_ge) begin
      next_pc = jump ? branchPc : seqPc;
      cycles = jump ? `CYC_TWO : `CYC_ONE;
    end
  end

  // Read mux; unmapped words read zero
  logic [31:0] readData;
  always_comb begin
    readData = 32'h00000000;
    unique case (word)
      `ADR_CTRL:   readData = ctrlWord;
      `ADR_OPA:    readData = {16'h0000, opA};
      `ADR_OPB:    readData = {24'h000000, opB};
      `ADR_IMM:    readData = {24'h000000, imm};
      `ADR_PTR:    readData = {16'h0000, ptr};
      `ADR_PC:     readData = 32'(pc);
      `ADR_FLAGS:  readData = {24'h000000, flags};
      `ADR_RESULT: readData = {16'h0000, result};
      `ADR_STATUS: readData = {26'h0000000, lastCycles, 1'b0, jumped, badOp,
                               state == running};
      default:     readData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= access & ~ack_o;
      dat_o <= (access & ~ack_o) ? readData : 32'h00000000;
    end
  end

  wire logic [31:0] newOpA = merge({16'h0000, opA}, dat_i, sel_i);
  wire logic [31:0] newOpB = merge({24'h000000, opB}, dat_i, sel_i);
  wire logic [31:0] newImm = merge({24'h000000, imm}, dat_i, sel_i);
  wire logic [31:0] newPtr = merge({16'h0000, ptr}, dat_i, sel_i);
  wire logic [31:0] newPc  = merge(32'(pc), dat_i, sel_i);
  wire logic [31:0] newFlg = merge({24'h000000, flags}, dat_i, sel_i);

  always_ff @(posedge clock) begin
    if (reset) begin
      opCode <= word_add_immediate;
      longNext <= 1'b0;
      opA <= 16'h0000;
      opB <= 8'h00;
      imm <= 8'h00;
      ptr <= 16'h0000;
    end else if (wrOk) begin
      unique case (word)
        `ADR_CTRL: begin
          if (opLegal) begin
            opCode <= op_e'(ctrlNew[4:0]);
          end
          longNext <= ctrlNew[`CTRL_LONG_BIT];
        end
        `ADR_OPA: opA <= newOpA[15:0];
        `ADR_OPB: opB <= newOpB[7:0];
        `ADR_IMM: imm <= newImm[7:0];
        `ADR_PTR: ptr <= newPtr[15:0];
        default: ;
      endcase
    end
  end

  // Sequencer: runs for exactly the operation's cycle count, commits on the last
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= idle;
      count <= 2'h0;
      busy <= 1'b0;
      badOp <= 1'b0;
    end else if (start) begin
      state <= running;
      count <= 2'h0;
      busy <= 1'b1;
      badOp <= 1'b0;
    end else if (state == running) begin
      count <= count + 2'h1;
      if (count + 2'h1 == cycles) begin
        state <= idle;
        busy <= 1'b0;
      end
    end else if (goReq) begin
      badOp <= 1'b1;
    end
  end

  wire logic endNow = (state == running) & (count + 2'h1 == cycles);

  always_ff @(posedge clock) begin
    if (reset) begin
      pc <= PC_BITS'(0);
      flags <= `FLAGS_RESET;
      result <= 16'h0000;
      jumped <= 1'b0;
      lastCycles <= 2'h0;
    end else if (endNow) begin
      pc <= next_pc;
      jumped <= jump;
      lastCycles <= cycles;
      if (isAlu | isMul) begin
        flags <= dataOut.flags;
        result <= dataOut.value;
      end else if (opCode == pointer_call) begin
        result <= seqPc[15:0];
      end
    end else if (wrOk & (word == `ADR_PC)) begin
      pc <= newPc[PC_BITS-1:0];
    end else if (wrOk & (word == `ADR_FLAGS)) begin
      flags <= newFlg[7:0];
    end
  end
endmodule

// [sim/cpu_exec_checker.sv]
// Port-level checks on the execution unit's bus and cycle sequencer
`timescale 1ns/100ps
module cpu_exec_checker #(
  parameter int PC_BITS = 22
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // A go that lands: control word written while idle, both low lanes enabled
  wire       goW = cyc_i && stb_i && we_i && ack_o && adr_i[7:2] == 6'h00
                   && dat_i[8] && sel_i[1:0] == 2'h3 && !busy;
  wire [4:0] opW = dat_i[4:0];
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  a_word_add: assert property (goW && opW == 5'h00 |=> busy [*2] ##1 !busy)
    else $error("word add length wrong");
  a_word_sub: assert property (goW && opW == 5'h01 |=> busy [*2] ##1 !busy)
    else $error("word subtract length wrong");
  a_byte_one: assert property (goW && opW inside {[2:4]} |=> busy ##1 !busy)
    else $error("byte operation length wrong");
  a_mul_two: assert property (goW && opW inside {[5:10]} |=> busy [*2] ##1 !busy)
    else $error("multiply length wrong");
  a_jump_two: assert property (goW && opW == 5'h0b |=> busy [*2] ##1 !busy)
    else $error("pointer jump length wrong");
  a_call_len: assert property (goW && opW == 5'h0c |=> busy [*2] ##1 (busy != (PC_BITS <= 16)))
    else $error("pointer call length wrong");
  a_skip_bound: assert property (goW && opW inside {[13:15]} |=> busy ##3 !busy)
    else $error("skip too long");
  a_branch_bound: assert property (goW && opW inside {[16:18]} |=> busy ##2 !busy)
    else $error("branch too long");
endmodule

// [sim/wb_master_model.sv]
// Classic Wishbone master standing in for the decoder side
`timescale 1ns/100ps
module wb_master_model (
  input  wire logic        clock,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [31:0]      dat,
  output logic [3:0]       sel,
  input  wire logic        ack,
  input  wire logic [31:0] datIn
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clock); while (ack !== 1'b1);
    q = datIn;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Released lines flip so a stale value never passes for held data
    adr <= ~a;
    dat <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    xfer(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, 4'hf, q);
  endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the execution unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench
  import cpu_exec_pkg::*;
;
  localparam int PC_BITS = 22;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        cyc, stb, we, ack, busy;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR, rd;
  int          errors = 0;
  int          comparisons = 0;
  int          ticks = 0;
  logic [15:0] prod [6] = '{16'hfe01, 16'h0001, 16'hff01, 16'hfc02, 16'h0002, 16'hfe02};
  initial forever #5 clock = ~clock;
  wb_master_model bus (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
                       .dat(datW), .sel(sel), .ack(ack), .datIn(datR));
  cpu_exec_unit #(.PC_BITS(PC_BITS)) dut_u (.clock(clock), .reset(reset), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(datW), .sel_i(sel), .ack_o(ack),
    .dat_o(datR), .busy(busy));
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    ticks++;
    if (ticks == 6000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic setup(input logic [15:0] opa, input logic [7:0] opb, imm,
                       input logic [15:0] ptr, input logic [31:0] pc, input logic [7:0] fl);
    bus.wr(8'h04, {16'h0, opa}, 4'hf);
    bus.wr(8'h08, {24'h0, opb}, 4'h1);
    bus.wr(8'h0c, {24'h0, imm}, 4'h1);
    bus.wr(8'h10, {16'h0, ptr}, 4'hf);
    bus.wr(8'h14, pc, 4'hf);
    bus.wr(8'h18, {24'h0, fl}, 4'h1);
  endtask
  // Runs one operation, counts busy cycles, then checks PC and flags
  task automatic run(input op_e op, input logic lng, input int n, input logic [31:0] pc,
                     input logic [7:0] fl);
    int k;
    bus.wr(8'h00, {22'h0, lng, 1'b1, 3'h0, op}, 4'h3);
    k = 0;
    @(negedge clock);
    while (busy === 1'b1 && k < 8) begin
      k++;
      @(negedge clock);
    end
    `CHK("cycles", n, k)
    bus.rd(8'h14, rd);
    `CHK("pc", pc, rd)
    bus.rd(8'h18, rd);
    `CHK("flags", {24'h0, fl}, rd)
    // Reported cycle count must match the expected count n
    bus.rd(8'h20, rd);
    `CHK("status cycles", n[1:0], rd[5:4])
  endtask
  task automatic res(input logic [31:0] e);
    bus.rd(8'h1c, rd);
    `CHK("result", e, rd)
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    setup(16'hffff, 8'h00, 8'hc1, 16'h0, 32'h10, 8'h20);
    run(word_add_immediate, 1'b0, 2, 32'h11, 8'h23);
    res(32'h0000);
    setup(16'h0000, 8'h00, 8'h01, 16'h0, 32'h10, 8'h20);
    run(word_sub_immediate, 1'b0, 2, 32'h11, 8'h35);
    res(32'hffff);
    setup(16'hab10, 8'h00, 8'h01, 16'h0, 32'h10, 8'h03);
    run(sub_imm_with_borrow, 1'b0, 1, 32'h11, 8'h20);
    res(32'hab0e);
    setup(16'h0080, 8'h00, 8'hf0, 16'h0, 32'h10, 8'h23);
    run(and_immediate, 1'b0, 1, 32'h11, 8'h35);
    res(32'h0080);
    setup(16'h5a00, 8'h00, 8'h00, 16'h0, 32'h10, 8'hdc);
    run(or_immediate, 1'b0, 1, 32'h11, 8'hc2);
    res(32'h5a00);
    for (int i = 0; i < 6; i++) begin
      setup(16'h00ff, 8'hff, 8'h00, 16'h0, 32'h10, 8'h3c);
      run(op_e'(5 + i), 1'b0, 2, 32'h11, {7'h1e, prod[i][15] | (i > 2 && i != 4)});
      res({16'h0, prod[i]});
    end
    setup(16'h0, 8'h00, 8'h00, 16'h1234, 32'h3f0010, 8'h3f);
    run(pointer_jump, 1'b0, 2, 32'h1234, 8'h3f);
    setup(16'h0, 8'h00, 8'h00, 16'habcd, 32'h3f0010, 8'h3f);
    run(pointer_call, 1'b0, 3, 32'habcd, 8'h3f);
    res(32'h0011);
    for (int j = 0; j < 3; j++) begin
      setup(16'h0055, (j == 2) ? 8'h54 : 8'h55, 8'h00, 16'h0, 32'h10, 8'h2a);
      run(compare_skip_equal, j == 1, 2 + j - 3 * (j / 2), 32'h12 + j - 3 * (j / 2), 8'h2a);
    end
    for (int b = 2; b < 4; b++) begin
      setup(16'h0004, 8'h00, b[7:0], 16'h0, 32'h10, 8'h15);
      run(io_bit_clear_skip, 1'b0, b - 1, 32'h0f + b, 8'h15);
      setup(16'h0004, 8'h00, b[7:0], 16'h0, 32'h10, 8'h15);
      run(io_bit_set_skip, 1'b0, 4 - b, 32'h14 - b, 8'h15);
    end
    setup(16'h0, 8'h00, 8'h7f, 16'h0, 32'h10, 8'h0c);
    run(branch_signed_ge, 1'b0, 2, 32'h10, 8'h0c);
    setup(16'h0, 8'h00, 8'h05, 16'h0, 32'h10, 8'h0c);
    run(branch_signed_lt, 1'b0, 1, 32'h11, 8'h0c);
    setup(16'h0, 8'h00, 8'h05, 16'h0, 32'h10, 8'h04);
    run(branch_signed_lt, 1'b0, 2, 32'h16, 8'h04);
    setup(16'h0, 8'h00, 8'h05, 16'h0, 32'h10, 8'h04);
    run(branch_signed_ge, 1'b0, 1, 32'h11, 8'h04);
    run(branch_half_carry_set, 1'b0, 1, 32'h12, 8'h04);
    setup(16'h0, 8'h00, 8'h40, 16'h0, 32'h10, 8'h20);
    run(branch_half_carry_set, 1'b0, 2, 32'h3fffd1, 8'h20);
    bus.wr(8'h00, {22'h0, 2'h1, 3'h0, 5'h13}, 4'h3);
    bus.rd(8'h20, rd);
    `CHK("illegal go", 2'h2, rd[1:0])
    bus.rd(8'h3c, rd);
    `CHK("unmapped", 32'h0, rd)
    tally_and_finish();
  end
endmodule
bind cpu_exec_unit cpu_exec_checker #(.PC_BITS(PC_BITS)) chk_u (.clock(clock), .reset(reset),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .ack_o(ack_o), .dat_o(dat_o), .busy(busy));
